/* File: rtl/scm_params.svh */
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH

// speed mode encoding
`define SCM_MODE_MIDDLE 2'h0
`define SCM_MODE_HIGH 2'h1
`define SCM_MODE_LOW 2'h2

// middle speed: phi toggles every fourth main edge (divide by eight)
`define SCM_MID_DIV_LAST 2'h3
// stop release count source divider (divide by sixteen)
`define SCM_SRC_DIV_LAST 4'hF
`define SCM_STAB_PRE_INIT 8'hFF
`define SCM_STAB_T1_INIT 8'h01
// auto switch wait in sub oscillator rising edges (two per low-speed cycle)
`define SCM_AUTO_SHORT 4'hA
`define SCM_AUTO_LONG 4'hE
// two-wire bus idles high; start the synchronisers there so reset shows no edge
`define SCM_BUS_IDLE 3'h7

// register offsets
`define SCM_ADDR_CTRL 12'h000
`define SCM_ADDR_CMD 12'h004
`define SCM_ADDR_TIMER 12'h008
`define SCM_ADDR_STATUS 12'h00C

// control register bits
`define SCM_B_MODE_LO 0
`define SCM_B_MODE_HI 1
`define SCM_B_STAB_SEL 2
`define SCM_B_AUTO_EN 3
`define SCM_B_AUTO_WAIT 4
`define SCM_B_MAIN_STOP 5
`define SCM_B_SUB_EN 6
`define SCM_CTRL_RESET 8'h00

// command register bits (write one to issue)
`define SCM_B_CMD_STOP 0
`define SCM_B_CMD_WAIT 1
`define SCM_B_CMD_IRQ 2

// timer register fields
`define SCM_TIMER_PRE_LO 0
`define SCM_TIMER_T1_LO 8

// status register bits
`define SCM_B_ST_MAIN_RUN 2
`define SCM_B_ST_SUB_RUN 3
`define SCM_B_ST_STOP 4
`define SCM_B_ST_WAIT 5
`define SCM_B_ST_PHI 6

`endif

/* File: rtl/scm_pkg.sv */
package scm_pkg;

  typedef enum logic [1:0] {
    SCM_RUN,
    SCM_WAIT,
    SCM_STOP,
    SCM_RESTART
  } scm_state_t;

  typedef struct packed {
    scm_state_t state;
    logic [1:0] mode;
    logic main_stop;
    logic stab_sel;
    logic auto_en;
    logic auto_wait;
    logic sub_en;
    logic [2:0] main_sync;
    logic [2:0] sub_sync;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic phi;
    logic [1:0] div;
    logic [3:0] src16;
    logic [7:0] pre_latch;
    logic [7:0] pre_cnt;
    logic [7:0] t1_latch;
    logic [7:0] t1_cnt;
    logic auto_busy;
    logic [3:0] auto_cnt;
  } scm_dev_state_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] pre;
    logic [7:0] t1;
    logic [31:0] prdata;
    logic ctrl_wr;
    logic stop_req;
    logic wait_req;
    logic irq;
    logic pre_load;
  } scm_host_state_t;

endpackage : scm_pkg

/* File: rtl/scm_if.sv */
interface scm_if;
  // control image, valid with ctrl_wr
  logic ctrl_wr;
  logic [1:0] mode;
  logic main_stop;
  logic stab_sel;
  logic auto_en;
  logic auto_wait;
  logic sub_en;
  // instruction and event pulses
  logic stop_req;
  logic wait_req;
  logic irq;
  // stabilise timer preload
  logic pre_load;
  logic [7:0] pre_val;
  logic [7:0] t1_val;
  // device status
  logic phi;
  logic [1:0] cur_mode;
  logic main_run;
  logic sub_run;
  logic halted_stop;
  logic halted_wait;

  modport dev (
    input ctrl_wr, mode, main_stop, stab_sel, auto_en, auto_wait, sub_en,
    input stop_req, wait_req, irq, pre_load, pre_val, t1_val,
    output phi, cur_mode, main_run, sub_run, halted_stop, halted_wait
  );

  modport host (
    output ctrl_wr, mode, main_stop, stab_sel, auto_en, auto_wait, sub_en,
    output stop_req, wait_req, irq, pre_load, pre_val, t1_val,
    input phi, cur_mode, main_run, sub_run, halted_stop, halted_wait
  );
endinterface : scm_if

/* File: rtl/scm_dev.sv */
// What this block does
// - middle speed is main over eight; reset default
// - high speed is main over two
// - low speed is sub over two
// - main stop bit stops main oscillator
// - software waits for main restart to settle
// - software keeps both stable; main above 3x sub
// - stop holds phi high, stops both oscillators
// - stop with select zero loads FF and 01
// - select one leaves prescaler and timer alone
// - release counts oscillator over sixteen, cascaded
// - interrupt restarts; phi held until timer underflow
// - reset release from stop has no wait
// - wait holds phi high; interrupt resumes at once
// - software enables releasing interrupts beforehand
// - software clears timer interrupt enable before stop
// - bus pin edge in low speed switches to middle
// - auto switch waits 4.5-5.5 or 6.5-7.5 cycles
// - timer loaded n divides by n plus one
// - after power-on only main runs; sub pins ports
//
// Our own choices: the APB register port and the address map.
`include "scm_params.svh"

module scm_dev (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // oscillator pins
  input wire logic main_osc_in,
  input wire logic sub_osc_in,
  output logic sub_osc_out,
  output logic sub_osc_out_oe,
  output logic sub_pins_as_port,
  // two-wire bus pins, watched only
  input wire logic bus_scl_in,
  input wire logic bus_sda_in,
  // link to the controlling party
  scm_if.dev link
);

  scm_pkg::scm_dev_state_t q;
  scm_pkg::scm_dev_state_t next_q;

  // counter step of a reloading down counter: n gives n+1 ticks per underflow
  function automatic logic [7:0] scm_dn_next(input logic [7:0] cnt, input logic [7:0] latch);
    scm_dn_next = (cnt == 8'h00) ? latch : cnt - 8'h01;
  endfunction : scm_dn_next

  function automatic logic scm_edge(input logic [2:0] s);
    scm_edge = s[1] ^ s[2];
  endfunction : scm_edge

  logic main_live;
  logic sub_live;
  logic main_rise;
  logic sub_rise;
  logic src_rise;
  logic bus_edge;
  logic [3:0] auto_limit;

  always_comb
  begin
    // main stops on its bit or in stop; sub only runs once enabled
    main_live = ~q.main_stop && (q.state != scm_pkg::SCM_STOP);
    sub_live = q.sub_en && (q.state != scm_pkg::SCM_STOP);
    main_rise = q.main_sync[1] & ~q.main_sync[2] & main_live;
    sub_rise = q.sub_sync[1] & ~q.sub_sync[2] & sub_live;
    src_rise = (q.mode == `SCM_MODE_LOW) ? sub_rise : main_rise;
    bus_edge = scm_edge(q.scl_sync) | scm_edge(q.sda_sync);
    auto_limit = q.auto_wait ? `SCM_AUTO_LONG : `SCM_AUTO_SHORT;
  end

  always_comb
  begin
    next_q = q;
    next_q.main_sync = {q.main_sync[1:0], main_osc_in};
    next_q.sub_sync = {q.sub_sync[1:0], sub_osc_in};
    next_q.scl_sync = {q.scl_sync[1:0], bus_scl_in};
    next_q.sda_sync = {q.sda_sync[1:0], bus_sda_in};

    if (link.ctrl_wr)
    begin
      next_q.mode = link.mode;
      next_q.main_stop = link.main_stop;
      next_q.stab_sel = link.stab_sel;
      next_q.auto_en = link.auto_en;
      next_q.auto_wait = link.auto_wait;
      next_q.sub_en = link.sub_en;
      next_q.div = 2'h0;
    end
    if (link.pre_load)
    begin
      next_q.pre_latch = link.pre_val;
      next_q.pre_cnt = link.pre_val;
      next_q.t1_latch = link.t1_val;
      next_q.t1_cnt = link.t1_val;
    end

    case (q.state)
      scm_pkg::SCM_RUN:
      begin
        if (src_rise)
        begin
          if (q.mode == `SCM_MODE_MIDDLE)
          begin
            next_q.div = q.div + 2'h1;
            if (q.div == `SCM_MID_DIV_LAST)
            begin
              next_q.phi = ~q.phi;
            end
          end
          else
          begin
            next_q.phi = ~q.phi;
          end
        end
        // bus activity in low speed brings main back and moves to middle
        if (q.mode == `SCM_MODE_LOW && q.auto_en && !q.auto_busy && bus_edge)
        begin
          next_q.auto_busy = 1'b1;
          next_q.main_stop = 1'b0;
          next_q.auto_cnt = 4'h0;
        end
        if (q.auto_busy && sub_rise)
        begin
          next_q.auto_cnt = q.auto_cnt + 4'h1;
          if (q.auto_cnt + 4'h1 == auto_limit)
          begin
            next_q.mode = `SCM_MODE_MIDDLE;
            next_q.auto_busy = 1'b0;
            next_q.div = 2'h0;
          end
        end
        if (link.stop_req)
        begin
          next_q.state = scm_pkg::SCM_STOP;
          next_q.phi = 1'b1;
          next_q.auto_busy = 1'b0;
          if (!q.stab_sel && !link.pre_load)
          begin
            next_q.pre_latch = `SCM_STAB_PRE_INIT;
            next_q.pre_cnt = `SCM_STAB_PRE_INIT;
            next_q.t1_latch = `SCM_STAB_T1_INIT;
            next_q.t1_cnt = `SCM_STAB_T1_INIT;
          end
        end
        else if (link.wait_req)
        begin
          next_q.state = scm_pkg::SCM_WAIT;
          next_q.phi = 1'b1;
          next_q.auto_busy = 1'b0;
        end
      end
      scm_pkg::SCM_WAIT:
      begin
        if (link.irq)
        begin
          // oscillators never stopped, so no settling time is owed
          next_q.state = scm_pkg::SCM_RUN;
          next_q.div = 2'h0;
        end
      end
      scm_pkg::SCM_STOP:
      begin
        if (link.irq)
        begin
          next_q.state = scm_pkg::SCM_RESTART;
          next_q.src16 = 4'h0;
        end
      end
      scm_pkg::SCM_RESTART:
      begin
        // phi stays high here until timer 1 runs out
        if (src_rise)
        begin
          next_q.src16 = q.src16 + 4'h1;
          if (q.src16 == `SCM_SRC_DIV_LAST)
          begin
            next_q.pre_cnt = scm_dn_next(q.pre_cnt, q.pre_latch);
            if (q.pre_cnt == 8'h00)
            begin
              next_q.t1_cnt = scm_dn_next(q.t1_cnt, q.t1_latch);
              if (q.t1_cnt == 8'h00)
              begin
                next_q.state = scm_pkg::SCM_RUN;
                next_q.div = 2'h0;
              end
            end
          end
        end
      end
      default:
      begin
        next_q.state = scm_pkg::SCM_RUN;
      end
    endcase
  end

  // reset drops straight into running middle speed, even out of stop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.state <= scm_pkg::SCM_RUN;
      q.mode <= `SCM_MODE_MIDDLE;
      q.phi <= 1'b1;
      q.pre_latch <= `SCM_STAB_PRE_INIT;
      q.pre_cnt <= `SCM_STAB_PRE_INIT;
      q.t1_latch <= `SCM_STAB_T1_INIT;
      q.t1_cnt <= `SCM_STAB_T1_INIT;
      q.scl_sync <= `SCM_BUS_IDLE;
      q.sda_sync <= `SCM_BUS_IDLE;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign link.phi = q.phi;
  assign link.cur_mode = q.mode;
  assign link.main_run = main_live;
  assign link.sub_run = sub_live;
  assign link.halted_stop = (q.state == scm_pkg::SCM_STOP) || (q.state == scm_pkg::SCM_RESTART);
  assign link.halted_wait = (q.state == scm_pkg::SCM_WAIT);
  // inverting amplifier stand-in; pins are plain ports until enabled
  assign sub_osc_out = ~q.sub_sync[2];
  assign sub_osc_out_oe = sub_live;
  assign sub_pins_as_port = ~q.sub_en;

endmodule : scm_dev

/* File: rtl/scm_host.sv */
`include "scm_params.svh"

module scm_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to the clock controller
  scm_if.host link
);

  scm_pkg::scm_host_state_t q;
  scm_pkg::scm_host_state_t next_q;

  function automatic logic scm_addr_ok(input logic [11:0] a);
    scm_addr_ok = (a == `SCM_ADDR_CTRL) || (a == `SCM_ADDR_CMD) ||
                  (a == `SCM_ADDR_TIMER) || (a == `SCM_ADDR_STATUS);
  endfunction : scm_addr_ok

  logic wr;
  logic [7:0] status;

  always_comb
  begin
    wr = psel && penable && pwrite && scm_addr_ok(paddr);
    status = 8'h00;
    status[`SCM_B_MODE_HI:`SCM_B_MODE_LO] = link.cur_mode;
    status[`SCM_B_ST_MAIN_RUN] = link.main_run;
    status[`SCM_B_ST_SUB_RUN] = link.sub_run;
    status[`SCM_B_ST_STOP] = link.halted_stop;
    status[`SCM_B_ST_WAIT] = link.halted_wait;
    status[`SCM_B_ST_PHI] = link.phi;
  end

  always_comb
  begin
    next_q = q;
    next_q.ctrl_wr = 1'b0;
    next_q.stop_req = 1'b0;
    next_q.wait_req = 1'b0;
    next_q.irq = 1'b0;
    next_q.pre_load = 1'b0;
    // read data is captured in the setup cycle, so access needs no wait
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `SCM_ADDR_CTRL: next_q.prdata = {24'h000000, q.ctrl};
        `SCM_ADDR_TIMER: next_q.prdata = {16'h0000, q.t1, q.pre};
        `SCM_ADDR_STATUS: next_q.prdata = {24'h000000, status};
        default: next_q.prdata = 32'h00000000;
      endcase
    end
    if (wr)
    begin
      case (paddr)
        `SCM_ADDR_CTRL:
        begin
          next_q.ctrl = pwdata[7:0];
          next_q.ctrl_wr = 1'b1;
        end
        `SCM_ADDR_CMD:
        begin
          next_q.stop_req = pwdata[`SCM_B_CMD_STOP];
          next_q.wait_req = pwdata[`SCM_B_CMD_WAIT] & ~pwdata[`SCM_B_CMD_STOP];
          next_q.irq = pwdata[`SCM_B_CMD_IRQ];
        end
        `SCM_ADDR_TIMER:
        begin
          next_q.pre = pwdata[`SCM_TIMER_PRE_LO +: 8];
          next_q.t1 = pwdata[`SCM_TIMER_T1_LO +: 8];
          next_q.pre_load = 1'b1;
        end
        default:
        begin
          next_q.pre_load = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.ctrl <= `SCM_CTRL_RESET;
      q.pre <= `SCM_STAB_PRE_INIT;
      q.t1 <= `SCM_STAB_T1_INIT;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !scm_addr_ok(paddr);

  assign link.ctrl_wr = q.ctrl_wr;
  assign link.mode = q.ctrl[`SCM_B_MODE_HI:`SCM_B_MODE_LO];
  assign link.main_stop = q.ctrl[`SCM_B_MAIN_STOP];
  assign link.stab_sel = q.ctrl[`SCM_B_STAB_SEL];
  assign link.auto_en = q.ctrl[`SCM_B_AUTO_EN];
  assign link.auto_wait = q.ctrl[`SCM_B_AUTO_WAIT];
  assign link.sub_en = q.ctrl[`SCM_B_SUB_EN];
  assign link.stop_req = q.stop_req;
  assign link.wait_req = q.wait_req;
  assign link.irq = q.irq;
  assign link.pre_load = q.pre_load;
  assign link.pre_val = q.pre;
  assign link.t1_val = q.t1;

endmodule : scm_host

/* File: verif/scm_chk.sv */
module scm_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host to device
  input wire logic ctrl_wr,
  input wire logic [1:0] mode,
  input wire logic main_stop,
  input wire logic stop_req,
  input wire logic wait_req,
  input wire logic irq,
  // device to host
  input wire logic phi,
  input wire logic [1:0] cur_mode,
  input wire logic main_run,
  input wire logic sub_run,
  input wire logic halted_stop,
  input wire logic halted_wait
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // requests are refused outside the run state
  wire running = !halted_stop && !halted_wait;

  stop_enter_a: assert property (stop_req && running |=> halted_stop)
    else $error("stop state not entered");
  osc_halt_a: assert property ($rose(halted_stop) |-> !main_run && !sub_run)
    else $error("oscillators still run in stop");
  phi_high_a: assert property (halted_stop || halted_wait |-> phi)
    else $error("phi not held high while halted");
  wait_enter_a: assert property (wait_req && !stop_req && running |=> halted_wait)
    else $error("wait state not entered");
  osc_keep_a: assert property ($rose(halted_wait) |-> $stable(main_run) && $stable(sub_run))
    else $error("oscillator changed on wait entry");
  wait_wake_a: assert property (halted_wait && irq |-> ##[1:2] !halted_wait)
    else $error("wait not left at once");
  stop_wake_a: assert property (halted_stop && irq && !main_run && !sub_run
    |-> ##[1:3] (main_run || sub_run))
    else $error("oscillator not restarted by interrupt");
  mode_take_a: assert property (ctrl_wr && running && mode != 2'h3
    |=> cur_mode == $past(mode))
    else $error("speed mode not taken");
  main_gate_a: assert property (ctrl_wr && !halted_stop
    |=> main_run == !$past(main_stop))
    else $error("main oscillator does not follow stop bit");

  cover property (halted_stop ##1 !halted_stop);
  cover property (halted_wait ##1 !halted_wait);
  cover property (cur_mode == 2'h2 ##1 cur_mode == 2'h0);
endmodule : scm_chk

/* File: verif/test_system_clock_mode_control.sv */
`include "scm_params.svh"

module test_system_clock_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic main_osc, sub_osc, scl, sda, as_port, sub_oe, sub_out;
  logic [3:0] sc;
  int error_cnt, cmp_count;

  scm_if link ();
  scm_host i_scm_host (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  scm_dev i_scm_dev (.clk(clk), .rst(rst), .main_osc_in(main_osc),
    .sub_osc_in(sub_osc), .sub_osc_out(sub_out), .sub_osc_out_oe(sub_oe),
    .sub_pins_as_port(as_port), .bus_scl_in(scl), .bus_sda_in(sda), .link(link));
  scm_chk i_scm_chk (.clk(clk), .rst(rst), .ctrl_wr(link.ctrl_wr), .mode(link.mode),
    .main_stop(link.main_stop), .stop_req(link.stop_req), .wait_req(link.wait_req),
    .irq(link.irq), .phi(link.phi), .cur_mode(link.cur_mode), .main_run(link.main_run),
    .sub_run(link.sub_run), .halted_stop(link.halted_stop),
    .halted_wait(link.halted_wait));

  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // resonators only swing while the device lets them run
  always @(posedge clk)
  begin
    sc <= sc + 4'h1;
    // full swing from the first edge, main sixteen times faster than sub
    if (link.main_run === 1'h1)
      main_osc <= ~main_osc;
    if (link.sub_run === 1'h1 && sc == 4'hF)
      sub_osc <= ~sub_osc;
  end

  task end_sim;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      end_sim();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  function automatic logic pick(int k);
    logic [3:0] s;
    s = {link.phi, link.cur_mode == 2'h0, link.halted_wait, link.halted_stop};
    return s[k];
  endfunction : pick

  // sampled on the falling edge, clear of the design's own updates
  task wt(input int k, input logic v, output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (n > 40000)
      begin
        error_cnt++;
        end_sim();
      end
    end
    while (pick(k) !== v);
  endtask : wt

  task per(output int p);
    int a, b;
    wt(3, 1'h0, a);
    wt(3, 1'h1, a);
    wt(3, 1'h0, a);
    wt(3, 1'h1, b);
    p = a + b;
  endtask : per

  task t_reset;
    chk(as_port, 1'h1);
    apb(1'h0, `SCM_ADDR_CTRL, 32'h0);
    chk(rv, 32'h0);
    apb(1'h0, `SCM_ADDR_TIMER, 32'h0);
    chk(rv, 32'h1FF);
    apb(1'h0, `SCM_ADDR_STATUS, 32'h0);
    chk(rv & 32'h3F, 32'h4);
    apb(1'h0, 12'h010, 32'h0);
    chk(rv, 32'h0);
    chk(ev, 1'h1);
  endtask : t_reset

  task t_speed;
    int p;
    for (int m = 0; m < 3; m++)
    begin
      apb(1'h1, `SCM_ADDR_CTRL, 32'h40 | m);
      repeat (130) @(negedge clk);
      per(p);
      chk(p, m == 0 ? 16 : m == 1 ? 4 : 64);
    end
  endtask : t_speed

  task t_wait;
    int n;
    apb(1'h1, `SCM_ADDR_CMD, 32'h2);
    wt(1, 1'h1, n);
    chk(n < 4, 1'h1);
    repeat (40) @(negedge clk);
    chk({link.phi, link.halted_wait, link.main_run}, 3'h7);
    apb(1'h1, `SCM_ADDR_CMD, 32'h4);
    wt(1, 1'h0, n);
    chk(n < 4, 1'h1);
  endtask : t_wait

  // release time is the timer product at two clocks per main edge
  task stop_run(input logic [7:0] c, input int exp);
    int n;
    apb(1'h1, `SCM_ADDR_CTRL, {24'h0, c});
    apb(1'h1, `SCM_ADDR_CMD, 32'h1);
    wt(0, 1'h1, n);
    repeat (60) @(negedge clk);
    chk({link.phi, link.halted_stop, link.main_run, link.sub_run}, 4'hC);
    apb(1'h1, `SCM_ADDR_CMD, 32'h4);
    wt(0, 1'h0, n);
    chk(n > exp - 12 && n < exp + 12, 1'h1);
    chk(link.main_run, 1'h1);
  endtask : stop_run

  task t_main;
    apb(1'h1, `SCM_ADDR_CTRL, 32'h62);
    repeat (8) @(negedge clk);
    apb(1'h0, `SCM_ADDR_STATUS, 32'h0);
    chk(rv & 32'hF, 32'hA);
    chk({as_port, sub_oe}, 2'h1);
    // sub pin shows the inverse once the synchroniser has settled
    @(negedge clk);
    repeat (16)
      if (sc != 4'h8)
        @(negedge clk);
    chk(sub_out ^ sub_osc, 1'h1);
    apb(1'h1, `SCM_ADDR_CTRL, 32'h42);
    apb(1'h0, `SCM_ADDR_STATUS, 32'h0);
    chk(rv & 32'hF, 32'hE);
  endtask : t_main

  task t_auto;
    int n;
    for (int k = 0; k < 2; k++)
    begin
      apb(1'h1, `SCM_ADDR_CTRL, 32'h6A | (k << 4));
      repeat (100) @(negedge clk);
      @(posedge clk);
      if (k == 0)
        scl <= ~scl;
      else
        sda <= ~sda;
      wt(2, 1'h1, n);
      chk(n > (k ? 408 : 280) && n < (k ? 488 : 360), 1'h1);
      chk(link.main_run, 1'h1);
    end
  endtask : t_auto

  // reset out of stop gives the clock back at once, in middle speed
  task t_rst_stop;
    int n;
    apb(1'h1, `SCM_ADDR_CMD, 32'h1);
    wt(0, 1'h1, n);
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk({link.halted_stop, link.main_run, link.cur_mode, link.phi}, 5'h09);
    t_reset();
  endtask : t_rst_stop

  initial
  begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    main_osc = 1'h0;
    sub_osc = 1'h0;
    scl = 1'h1;
    sda = 1'h1;
    sc = 4'h0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_speed();
    t_wait();
    apb(1'h1, `SCM_ADDR_TIMER, 32'h103);
    stop_run(8'h04, 256);
    stop_run(8'h00, 16384);
    t_main();
    t_auto();
    t_rst_stop();
    end_sim();
  end
endmodule : test_system_clock_mode_control
